// File: core/anm_host_ctrl.v
// Purpose: host controller driving an asynchronous 256K x 16 non-volatile memory port
// Assumes: 20 MHz mclk; supplyOk is an asynchronous level from a supply monitor
// Notes: one access at a time; reqReady is the handshake for the user side
// Overview of operation
// - after supply rises the controller waits 2 ms before any read or write.
// - the controller holds chip select and write strobe high through power-up lockout.
// - after a brownout seen in idle or lockout the controller waits the full startup interval again.
// - each read cycle between address changes lasts at least 35 ns.
`timescale 1ns/1ns
`include "anm_consts.vh"
module anm_host_ctrl #(
  parameter ADDR_W = `ANM_ADDR_W,
  parameter STARTUP_CYC = `ANM_STARTUP_CYC
) (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // supply monitor
  input wire supplyOk,
  // user request side
  input wire reqValid,
  output wire reqReady,
  input wire reqWrite,
  input wire [ADDR_W-1:0] reqAddr,
  input wire [1:0] reqByteEn,
  input wire [15:0] reqWdata,
  output reg rspValid,
  output reg [15:0] rspRdata,
  output wire memReady,
  // memory pins
  output reg [ADDR_W-1:0] memAddr,
  output reg chipSelect_n,
  output reg writeStrobe_n,
  output reg outputDrive_n,
  output reg low_byte_select_n,
  output reg high_byte_select_n,
  input wire [7:0] lowByteLaneIn,
  output reg [7:0] lowByteLaneOut,
  output reg lowByteLaneOe,
  input wire [7:0] highByteLaneIn,
  output reg [7:0] highByteLaneOut,
  output reg highByteLaneOe
);
  ////////////////////////////////////////////////////////////////////////////
  localparam ST_LOCK = `ANM_ST_LOCK;
  localparam ST_IDLE = `ANM_ST_IDLE;
  localparam ST_RDWAIT = `ANM_ST_RDWAIT;
  localparam ST_RDCAP = `ANM_ST_RDCAP;
  localparam ST_WRPULSE = `ANM_ST_WRPULSE;
  localparam ST_WREND = `ANM_ST_WREND;
  // counts are worked out as integers, then cut to the phase counter width on purpose
  localparam integer RD_CYC_I = `ANM_ACCESS_CYC;
  localparam integer WR_CYC_I = `ANM_WR_PULSE_CYC;
  localparam [2:0] RD_CYC = RD_CYC_I[2:0];
  localparam [2:0] WR_CYC = WR_CYC_I[2:0];
  localparam [31:0] LOCK_LAST = STARTUP_CYC - 1;

  wire supplyOkSync;
  wire [15:0] laneSync;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] lockCnt_q;
  reg [2:0] phaseCnt_q;

  // lanes are sampled after the access time, but still pass two flops
  anm_sync2 #(.WIDTH(1)) uSupply (
    .mclk(mclk),
    .nrst(nrst),
    .asyncIn(supplyOk),
    .syncOut(supplyOkSync)
  );
  anm_sync2 #(.WIDTH(16)) uLanes (
    .mclk(mclk),
    .nrst(nrst),
    .asyncIn({highByteLaneIn, lowByteLaneIn}),
    .syncOut(laneSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // only idle with at least one lane named as valid is a legal access
  assign memReady = (state_q == ST_IDLE);
  assign reqReady = memReady && supplyOkSync;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_LOCK: begin
        if (supplyOkSync && lockCnt_q == LOCK_LAST) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!supplyOkSync) begin
          state_d = ST_LOCK;
        end else if (reqValid && reqByteEn != 2'h0) begin
          state_d = reqWrite ? ST_WRPULSE : ST_RDWAIT;
        end
      end
      ST_RDWAIT: begin
        // two extra cycles cover the lane synchroniser
        if (phaseCnt_q == RD_CYC + 3'h1) begin
          state_d = ST_RDCAP;
        end
      end
      ST_RDCAP: state_d = ST_IDLE;
      ST_WRPULSE: begin
        if (phaseCnt_q == WR_CYC - 3'h1) begin
          state_d = ST_WREND;
        end
      end
      ST_WREND: state_d = ST_IDLE;
      default: state_d = ST_LOCK;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_LOCK;
      lockCnt_q <= 32'h0;
      phaseCnt_q <= 3'h0;
    end else begin
      state_q <= state_d;
      // counter restarts whenever the supply drops out
      if (!supplyOkSync) begin
        lockCnt_q <= 32'h0;
      end else if (state_q == ST_LOCK && lockCnt_q != LOCK_LAST) begin
        lockCnt_q <= lockCnt_q + 32'h1;
      end else if (state_q != ST_LOCK) begin
        lockCnt_q <= 32'h0;
      end
      if (state_d != state_q) begin
        phaseCnt_q <= 3'h0;
      end else begin
        phaseCnt_q <= phaseCnt_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: every strobe and select idles high and the lanes undriven (memAddr keeps the last address), so the device sees no access
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      memAddr <= {ADDR_W{1'b0}};
      chipSelect_n <= 1'b1;
      writeStrobe_n <= 1'b1;
      outputDrive_n <= 1'b1;
      low_byte_select_n <= 1'b1;
      high_byte_select_n <= 1'b1;
      lowByteLaneOut <= 8'h0;
      highByteLaneOut <= 8'h0;
      lowByteLaneOe <= 1'b0;
      highByteLaneOe <= 1'b0;
      rspValid <= 1'b0;
      rspRdata <= 16'h0;
    end else begin
      rspValid <= 1'b0;
      case (state_d)
        ST_RDWAIT, ST_RDCAP: begin
          chipSelect_n <= 1'b0;
          outputDrive_n <= 1'b0;
          writeStrobe_n <= 1'b1;
          lowByteLaneOe <= 1'b0;
          highByteLaneOe <= 1'b0;
        end
        ST_WRPULSE: begin
          chipSelect_n <= 1'b0;
          outputDrive_n <= 1'b1;
          writeStrobe_n <= 1'b0;
        end
        ST_WREND: begin
          // strobe rises while data and address still stand
          writeStrobe_n <= 1'b1;
          chipSelect_n <= 1'b0;
        end
        default: begin
          chipSelect_n <= 1'b1;
          writeStrobe_n <= 1'b1;
          outputDrive_n <= 1'b1;
          low_byte_select_n <= 1'b1;
          high_byte_select_n <= 1'b1;
          lowByteLaneOe <= 1'b0;
          highByteLaneOe <= 1'b0;
        end
      endcase
      if (state_q == ST_IDLE && state_d != ST_IDLE && state_d != ST_LOCK) begin
        memAddr <= reqAddr;
        low_byte_select_n <= ~reqByteEn[0];
        high_byte_select_n <= ~reqByteEn[1];
        lowByteLaneOut <= reqWdata[7:0];
        highByteLaneOut <= reqWdata[15:8];
        // an unselected lane is never driven on a write
        lowByteLaneOe <= reqWrite & reqByteEn[0];
        highByteLaneOe <= reqWrite & reqByteEn[1];
      end
      if (state_q == ST_RDCAP) begin
        // address held at least two cycles, well past the least read cycle
        rspValid <= 1'b1;
        // an unselected lane reads back as zero, never as a floating pin
        if (low_byte_select_n) begin
          rspRdata[7:0] <= 8'h0;
        end else begin
          rspRdata[7:0] <= laneSync[7:0];
        end
        if (high_byte_select_n) begin
          rspRdata[15:8] <= 8'h0;
        end else begin
          rspRdata[15:8] <= laneSync[15:8];
        end
      end else if (state_q == ST_WREND) begin
        rspValid <= 1'b1;
      end
    end
  end
endmodule // anm_host_ctrl

// File: core/anm_consts.vh
// Purpose: shared constants for the host port controller of the nv word memory
// Assumes: 20 MHz mclk, 50 ns period
// Notes: times kept in their own unit, cycle counts derived from them
`ifndef ANM_CONSTS_VH
`define ANM_CONSTS_VH
`define ANM_CLK_PERIOD_NS 50
`define ANM_CLK_HZ 20000000
`define ANM_ADDR_W 18
`define ANM_DATA_W 16
`define ANM_WORDS 262144
`define ANM_STARTUP_US 2000
`define ANM_STARTUP_CYC ((`ANM_STARTUP_US * 20) + 1)
`define ANM_RD_CYCLE_NS 35
`define ANM_RD_CYCLE_CYC ((`ANM_RD_CYCLE_NS + `ANM_CLK_PERIOD_NS - 1) / `ANM_CLK_PERIOD_NS)
`define ANM_ACCESS_NS 35
`define ANM_ACCESS_CYC ((`ANM_ACCESS_NS + `ANM_CLK_PERIOD_NS - 1) / `ANM_CLK_PERIOD_NS)
`define ANM_WR_PULSE_NS 15
`define ANM_WR_PULSE_CYC ((`ANM_WR_PULSE_NS + `ANM_CLK_PERIOD_NS - 1) / `ANM_CLK_PERIOD_NS)
`define ANM_ST_LOCK 3'h0
`define ANM_ST_IDLE 3'h1
`define ANM_ST_RDWAIT 3'h2
`define ANM_ST_RDCAP 3'h3
`define ANM_ST_WRPULSE 3'h4
`define ANM_ST_WREND 3'h5
`endif

// File: core/anm_sync2.v
// Purpose: two-flop synchroniser for a level from outside mclk
// Assumes: first flop read only by the second
// Notes: reset value is all zeros at every width
`timescale 1ns/1ns
module anm_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // data
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_q;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // anm_sync2

// File: verification/anm_mem_model.sv
// Purpose: behavioural 256K x 16 nv word memory seen from its pins
// Assumes: lanes resolved by the bench; no clock of its own
// Notes: a lane it does not drive shows the inverse of the stored byte
`timescale 1ns/1ns
module anm_mem_model (
  // supply and control
  input wire supplyOk,
  input wire [17:0] memAddr,
  input wire chipSelect_n,
  input wire writeStrobe_n,
  input wire outputDrive_n,
  input wire low_byte_select_n,
  input wire high_byte_select_n,
  // lanes
  input wire [7:0] lowWr,
  input wire [7:0] highWr,
  output wire [7:0] lowRd,
  output wire [7:0] highRd
);
  reg [15:0] mem [0:262143];
  wire rd;
  assign rd = !chipSelect_n && !outputDrive_n && writeStrobe_n;
  assign lowRd = (rd && !low_byte_select_n) ? mem[memAddr][7:0] : ~mem[memAddr][7:0];
  assign highRd = (rd && !high_byte_select_n) ? mem[memAddr][15:8] : ~mem[memAddr][15:8];
  // store at the end of the strobe; low supply blocks it
  always @(posedge writeStrobe_n) begin
    if (chipSelect_n === 1'b0 && supplyOk === 1'b1) begin
      if (!low_byte_select_n) mem[memAddr][7:0] = lowWr;
      if (!high_byte_select_n) mem[memAddr][15:8] = highWr;
    end
  end
endmodule // anm_mem_model

// File: verification/anm_host_ctrl_props.sv
// Purpose: pin timing checks for the host controller
// Assumes: one clock domain
// Notes: upCnt_q runs ahead of the design's synced count, so it is a safe bound
`timescale 1ns/1ns
module anm_host_ctrl_props #(
  parameter STARTUP_CYC = 40001
) (
  input wire mclk,
  input wire nrst,
  input wire supplyOk,
  input wire reqValid,
  input wire reqReady,
  input wire reqWrite,
  input wire [1:0] reqByteEn,
  input wire rspValid,
  input wire memReady,
  input wire [17:0] memAddr,
  input wire chipSelect_n,
  input wire writeStrobe_n,
  input wire outputDrive_n,
  input wire low_byte_select_n,
  input wire high_byte_select_n,
  input wire lowByteLaneOe,
  input wire highByteLaneOe
);
  reg [31:0] upCnt_q;
  wire take;
  assign take = reqValid && reqReady && reqByteEn != 2'h0;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) upCnt_q <= 32'h0;
    else if (!supplyOk) upCnt_q <= 32'h0;
    else if (upCnt_q < STARTUP_CYC) upCnt_q <= upCnt_q + 32'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_lock; upCnt_q < STARTUP_CYC |-> chipSelect_n && writeStrobe_n; endproperty
  a_lock: assert property (p_lock) else $error("access in lockout");
  property p_ready; $rose(memReady) |-> upCnt_q == STARTUP_CYC; endproperty
  a_ready: assert property (p_ready) else $error("ready too early");
  property p_rd;
    $fell(outputDrive_n) |-> !chipSelect_n && writeStrobe_n
      ##1 (!outputDrive_n && $stable(memAddr))[*3] ##1 outputDrive_n;
  endproperty
  a_rd: assert property (p_rd) else $error("read cycle shape");
  property p_wr;
    $fell(writeStrobe_n) |-> !chipSelect_n && outputDrive_n
      && lowByteLaneOe == !low_byte_select_n && highByteLaneOe == !high_byte_select_n
      ##1 writeStrobe_n && !chipSelect_n && $stable(memAddr);
  endproperty
  a_wr: assert property (p_wr) else $error("write cycle shape");
  property p_oe; lowByteLaneOe || highByteLaneOe |-> outputDrive_n; endproperty
  a_oe: assert property (p_oe) else $error("lane contention");
  property p_sel; !chipSelect_n |-> !(low_byte_select_n && high_byte_select_n); endproperty
  a_sel: assert property (p_sel) else $error("empty access");
  property p_rrsp; take && !reqWrite |-> ##5 rspValid; endproperty
  a_rrsp: assert property (p_rrsp) else $error("read answer late");
  property p_wrsp; take && reqWrite |-> ##3 rspValid; endproperty
  a_wrsp: assert property (p_wrsp) else $error("write answer late");
endmodule // anm_host_ctrl_props
bind anm_host_ctrl anm_host_ctrl_props #(.STARTUP_CYC(STARTUP_CYC)) u_props (.mclk, .nrst,
  .supplyOk, .reqValid, .reqReady, .reqWrite, .reqByteEn, .rspValid, .memReady, .memAddr,
  .chipSelect_n, .writeStrobe_n, .outputDrive_n, .low_byte_select_n, .high_byte_select_n,
  .lowByteLaneOe, .highByteLaneOe);

// File: verification/anm_host_ctrl_tb.sv
// Purpose: self-checking bench for the host controller and memory model
// Assumes: short startup count so the run stays brief
// Notes: inputs change at the falling edge
`timescale 1ns/1ns
module anm_host_ctrl_tb;
  localparam SC = 50;
  reg mclk = 0;
  reg nrst = 0;
  reg supplyOk = 1;
  reg reqValid = 0;
  reg reqWrite = 0;
  reg [17:0] reqAddr = 0;
  reg [1:0] reqByteEn = 0;
  reg [15:0] reqWdata = 0;
  wire reqReady, rspValid, memReady, chipSelect_n, writeStrobe_n, outputDrive_n;
  wire low_byte_select_n, high_byte_select_n, lowByteLaneOe, highByteLaneOe;
  wire [15:0] rspRdata;
  wire [17:0] memAddr;
  wire [7:0] lowByteLaneOut, highByteLaneOut, lowRd, highRd, lowWire, highWire;
  integer mismatches = 0;
  integer num_checks = 0;
  assign lowWire = lowByteLaneOe ? lowByteLaneOut : lowRd;
  assign highWire = highByteLaneOe ? highByteLaneOut : highRd;
  always #25 mclk = ~mclk;
  anm_host_ctrl #(.STARTUP_CYC(SC)) dut (.mclk, .nrst, .supplyOk, .reqValid, .reqReady,
    .reqWrite, .reqAddr, .reqByteEn, .reqWdata, .rspValid, .rspRdata, .memReady, .memAddr,
    .chipSelect_n, .writeStrobe_n, .outputDrive_n, .low_byte_select_n, .high_byte_select_n,
    .lowByteLaneIn(lowWire), .lowByteLaneOut, .lowByteLaneOe, .highByteLaneIn(highWire),
    .highByteLaneOut, .highByteLaneOe);
  anm_mem_model mem (.supplyOk, .memAddr, .chipSelect_n, .writeStrobe_n, .outputDrive_n,
    .low_byte_select_n, .high_byte_select_n, .lowWr(lowWire), .highWr(highWire), .lowRd,
    .highRd);
  ////////////////////////////////////////////////////////////////////////////////////////
  task chk(input [17:0] seen, input [17:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task acc(input wr, input [17:0] a, input [1:0] be, input [15:0] d);
    integer n;
    @(negedge mclk);
    reqValid = 1;
    reqWrite = wr;
    reqAddr = a;
    reqByteEn = be;
    reqWdata = d;
    while (reqReady !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    reqValid = 0;
    // the take edge counts as the first one; the pulse is seen before the edge that samples it
    n = 1;
    while (rspValid !== 1'b1 && n < 10) begin
      @(negedge mclk);
      n = n + 1;
    end
    chk(n, wr ? 3 : 5);
  endtask
  task t_lock;
    integer n;
    n = 0;
    while (memReady !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n = n + 1;
    end
    chk(n >= SC && n < SC + 5, 1);
    $display("test lockout done");
  endtask
  task t_data;
    acc(1, 18'h3ffff, 2'h3, 16'ha55a);
    acc(1, 18'h00000, 2'h3, 16'h5aa5);
    acc(0, 18'h3ffff, 2'h3, 16'h0);
    chk(rspRdata, 16'ha55a);
    acc(0, 18'h00000, 2'h3, 16'h0);
    chk(rspRdata, 16'h5aa5);
    acc(1, 18'h3ffff, 2'h1, 16'hee11);
    acc(0, 18'h3ffff, 2'h3, 16'h0);
    chk(rspRdata, 16'ha511);
    acc(1, 18'h3ffff, 2'h2, 16'h22ee);
    acc(0, 18'h3ffff, 2'h2, 16'h0);
    chk(rspRdata, 16'h2200);
    acc(0, 18'h3ffff, 2'h1, 16'h0);
    chk(rspRdata, 16'h0011);
    // no byte selected: the request must be ignored, not turned into an access
    reqByteEn = 2'h0;
    reqValid = 1;
    repeat (4) @(negedge mclk);
    chk({rspValid, chipSelect_n}, 2'h1);
    reqValid = 0;
    $display("test data done");
  endtask
  task t_brown;
    supplyOk = 0;
    repeat (4) @(negedge mclk);
    chk(reqReady, 0);
    supplyOk = 1;
    t_lock;
    acc(0, 18'h3ffff, 2'h3, 16'h0);
    chk(rspRdata, 16'h2211);
    $display("test brownout done");
  endtask
  task close_out;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    nrst = 1;
    t_lock;
    t_data;
    t_brown;
    close_out;
  end
  // about twenty times the expected run
  initial begin
    #200000;
    mismatches = mismatches + 1;
    close_out;
  end
endmodule // anm_host_ctrl_tb
